// *** shared/fpr_pkg.sv ***
// Constants, register map and step table for the fan ramp limiter
package fpr_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_PWM = 4;
    localparam int NUM_CAP = 4;
    localparam int DUTY_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] SLOT_LAST = 8'hFE;
    localparam logic [7:0] SLOT_DIV_LAST = 8'h09;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_DYN_START_A = 8'h0B;
    localparam logic [7:0] OFF_SMOOTH_A = 8'h1A;
    localparam logic [7:0] OFF_SMOOTH_B = 8'h1B;
    localparam logic [7:0] OFF_PWM_CFG_0 = 8'h21;
    localparam logic [7:0] OFF_OP_POINT_0 = 8'h30;
    localparam logic [7:0] OFF_DUTY_0 = 8'h40;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CAP_LSB = 2;
    localparam int EN_LO_BIT = 0;
    localparam int EN_HI_BIT = 1;
    localparam int STEP_LO_LSB = 2;
    localparam int STEP_HI_LSB = 5;
    localparam int SLOW_BIT = 3;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_OP_POINT = 8'h00;
    localparam logic [7:0] RST_DUTY = 8'h00;
    localparam logic [1:0] SLOW_PHASE_LAST = 2'h3;

    // Step size in slots for a 3-bit code
    function automatic logic [7:0] fpr_step(input logic [2:0] code);
        logic [7:0] s;
        case (code)
            3'h0: s = 8'h01;
            3'h1: s = 8'h02;
            3'h2: s = 8'h03;
            3'h3: s = 8'h05;
            3'h4: s = 8'h08;
            3'h5: s = 8'h0C;
            3'h6: s = 8'h18;
            default: s = 8'h30;
        endcase
        return s;
    endfunction
endpackage

// *** logic/fpr_ramp_chan.sv ***
// One channel of duty-cycle rate limiting
`timescale 1ns/1ps
`default_nettype none
module fpr_ramp_chan
    import fpr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Control loop
    input wire logic update_i,
    input wire logic [7:0] target_i,
    // Configuration
    input wire logic smooth_en_i,
    input wire logic [2:0] step_code_i,
    input wire logic slow_i,
    // Applied duty
    output logic [7:0] duty_o
);
    logic [7:0] duty_reg;
    logic [7:0] duty_next;
    logic [1:0] phase_reg;
    logic [7:0] step;
    logic [7:0] gap;
    logic apply;

    assign step = fpr_step(step_code_i);
    assign apply = !slow_i || (phase_reg == SLOW_PHASE_LAST);
    assign gap = (target_i > duty_reg) ? target_i - duty_reg
                                       : duty_reg - target_i;

    always_comb begin
        duty_next = duty_reg;
        if (!smooth_en_i) begin
            duty_next = target_i;
        end else if (apply) begin
            if (gap <= step) begin
                duty_next = target_i;
            end else if (target_i > duty_reg) begin
                duty_next = duty_reg + step;
            end else begin
                duty_next = duty_reg - step;
            end
        end
    end

    // Stored duty doubles as the next comparison base
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            duty_reg <= RST_DUTY;
        end else if (update_i) begin
            duty_reg <= duty_next;
        end
    end

    // Quarter-rate stepping when slowed
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            phase_reg <= 2'h0;
        end else if (!smooth_en_i || !slow_i) begin
            phase_reg <= 2'h0;
        end else if (update_i) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end

    assign duty_o = duty_reg;

    property p_slow_hold;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        update_i && smooth_en_i && slow_i && phase_reg != 2'h3
            |=> $stable(duty_reg);
    endproperty
    a_slow_hold: assert property (p_slow_hold)
        else $error("slowed ramp moved between quarter updates");
endmodule
`default_nettype wire

// *** logic/fpr_pwm_gen.sv ***
// 255-slot PWM output for one channel
`timescale 1ns/1ps
`default_nettype none
module fpr_pwm_gen
    import fpr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Slot timing and duty
    input wire logic slot_en_i,
    input wire logic [7:0] duty_i,
    // Output
    output logic pwm_o
);
    logic [7:0] slot_reg;
    logic [7:0] duty_lat_reg;
    logic pwm_reg;

    // Slot counter 0..254, duty taken at period boundary
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slot_reg <= 8'h00;
            duty_lat_reg <= RST_DUTY;
        end else if (slot_en_i) begin
            if (slot_reg == SLOT_LAST) begin
                slot_reg <= 8'h00;
                duty_lat_reg <= duty_i;
            end else begin
                slot_reg <= slot_reg + 8'h01;
            end
        end
    end

    // High for duty slots out of 255
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pwm_reg <= 1'b0;
        end else begin
            pwm_reg <= (slot_reg < duty_lat_reg);
        end
    end

    assign pwm_o = pwm_reg;

    property p_slot_wrap;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        slot_en_i && slot_reg == 8'hFE |=> slot_reg == 8'h00;
    endproperty
    a_slot_wrap: assert property (p_slot_wrap)
        else $error("slot counter did not wrap after 255 slots");
endmodule
`default_nettype wire

// *** logic/fpr_fan_ramp_limiter.sv ***
// Fan duty smoothing and thermal-alarm operating point capture
//
// Overview of operation
// - Four capture-enable bits in start control register
// - Enabled channel captures temperature on alarm
// - Disabled channel keeps software operating point
// - Alarm input asserted when driven low
// - Smoothing off applies new duty immediately
// - Ctrl A bit 0 enables PWM A smoothing
// - Ctrl A bit 1 enables PWM B smoothing
// - Ctrl B bit 0 enables PWM C smoothing
// - Ctrl B bit 1 enables PWM D smoothing
// - Smoothing independent per PWM output
// - Period split into 255 equal slots
// - Higher target raises duty by step
// - Lower target lowers duty by step
// - Steps of 1,2,3,5,8,12,24,48 slots
// - Result stored as previous and driven out
// - One slot is 1/255 of period
// - PWM A step code in bits 4:2
// - Bits 7:5 for B; ctrl B for C,D
// - Slow bit steps every fourth update
`timescale 1ns/1ps
`default_nettype none
module fpr_fan_ramp_limiter
    import fpr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Control loop duties
    input wire logic [NUM_PWM-1:0][7:0] auto_duty_i,
    input wire logic [NUM_PWM-1:0] duty_update_i,
    // Remote temperatures
    input wire logic [NUM_CAP-1:0][7:0] remote_temp_i,
    // Thermal alarm pin
    input wire logic thermal_alarm_input_n_i,
    // Outputs
    output logic [NUM_PWM-1:0] pwm_o,
    output logic [NUM_CAP-1:0][7:0] op_point_o
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] dyn_start_ctrl_a_reg;
    logic [7:0] smooth_ctrl_a_reg;
    logic [7:0] smooth_ctrl_b_reg;
    logic [NUM_PWM-1:0][7:0] pwm_cfg_reg;
    logic [NUM_CAP-1:0][7:0] op_point_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic alarm_s1_reg;
    logic alarm_s2_reg;
    logic alarm_act;
    logic [NUM_CAP-1:0] cap_en;
    logic [NUM_PWM-1:0] smooth_en;
    logic [NUM_PWM-1:0][2:0] step_code;
    logic [NUM_PWM-1:0] slow;
    logic [NUM_PWM-1:0][7:0] duty_w;
    logic [7:0] slot_div_reg;
    logic slot_en;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dyn_start_ctrl_a_reg <= RST_CTRL;
        end else if (reg_wr_i && reg_addr_i == OFF_DYN_START_A) begin
            dyn_start_ctrl_a_reg <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            smooth_ctrl_a_reg <= RST_CTRL;
            smooth_ctrl_b_reg <= RST_CTRL;
        end else if (reg_wr_i) begin
            if (reg_addr_i == OFF_SMOOTH_A) begin
                smooth_ctrl_a_reg <= reg_wdata_i;
            end
            if (reg_addr_i == OFF_SMOOTH_B) begin
                smooth_ctrl_b_reg <= reg_wdata_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Thermal alarm synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            alarm_s1_reg <= 1'b1;
            alarm_s2_reg <= 1'b1;
        end else begin
            alarm_s1_reg <= thermal_alarm_input_n_i;
            alarm_s2_reg <= alarm_s1_reg;
        end
    end

    assign alarm_act = !alarm_s2_reg;
    assign cap_en = dyn_start_ctrl_a_reg[CAP_LSB +: NUM_CAP];

    // ------------------------------------------------------------
    // Per-channel field decode
    // ------------------------------------------------------------
    assign smooth_en[0] = smooth_ctrl_a_reg[EN_LO_BIT];
    assign smooth_en[1] = smooth_ctrl_a_reg[EN_HI_BIT];
    assign smooth_en[2] = smooth_ctrl_b_reg[EN_LO_BIT];
    assign smooth_en[3] = smooth_ctrl_b_reg[EN_HI_BIT];
    assign step_code[0] = smooth_ctrl_a_reg[STEP_LO_LSB +: 3];
    assign step_code[1] = smooth_ctrl_a_reg[STEP_HI_LSB +: 3];
    assign step_code[2] = smooth_ctrl_b_reg[STEP_LO_LSB +: 3];
    assign step_code[3] = smooth_ctrl_b_reg[STEP_HI_LSB +: 3];

    // ------------------------------------------------------------
    // Slot-rate divider shared by all outputs
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            slot_div_reg <= 8'h00;
        end else if (slot_div_reg == SLOT_DIV_LAST) begin
            slot_div_reg <= 8'h00;
        end else begin
            slot_div_reg <= slot_div_reg + 8'h01;
        end
    end

    assign slot_en = (slot_div_reg == SLOT_DIV_LAST);

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_PWM; g++) begin : g_pwm
            // Configuration register per output
            always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    pwm_cfg_reg[g] <= RST_CTRL;
                end else if (reg_wr_i &&
                    reg_addr_i == OFF_PWM_CFG_0 + 8'(g)) begin
                    pwm_cfg_reg[g] <= reg_wdata_i;
                end
            end

            assign slow[g] = pwm_cfg_reg[g][SLOW_BIT];

            // Each output has its own ramp state
            fpr_ramp_chan u_ramp (
                .ref_clk_i(ref_clk_i),
                .arst_n_i(arst_n_i),
                .update_i(duty_update_i[g]),
                .target_i(auto_duty_i[g]),
                .smooth_en_i(smooth_en[g]),
                .step_code_i(step_code[g]),
                .slow_i(slow[g]),
                .duty_o(duty_w[g])
            );

            fpr_pwm_gen u_pwm (
                .ref_clk_i(ref_clk_i),
                .arst_n_i(arst_n_i),
                .slot_en_i(slot_en),
                .duty_i(duty_w[g]),
                .pwm_o(pwm_o[g])
            );
        end

        for (g = 0; g < NUM_CAP; g++) begin : g_cap
            // Alarm capture beats a same-cycle software write
            always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    op_point_reg[g] <= RST_OP_POINT;
                end else if (cap_en[g] && alarm_act) begin
                    op_point_reg[g] <= remote_temp_i[g];
                end else if (reg_wr_i &&
                    reg_addr_i == OFF_OP_POINT_0 + 8'(g)) begin
                    op_point_reg[g] <= reg_wdata_i;
                end
            end

            assign op_point_o[g] = op_point_reg[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            OFF_DYN_START_A: rdata_next = dyn_start_ctrl_a_reg;
            OFF_SMOOTH_A: rdata_next = smooth_ctrl_a_reg;
            OFF_SMOOTH_B: rdata_next = smooth_ctrl_b_reg;
            OFF_PWM_CFG_0: rdata_next = pwm_cfg_reg[0];
            OFF_PWM_CFG_0 + 8'h01: rdata_next = pwm_cfg_reg[1];
            OFF_PWM_CFG_0 + 8'h02: rdata_next = pwm_cfg_reg[2];
            OFF_PWM_CFG_0 + 8'h03: rdata_next = pwm_cfg_reg[3];
            OFF_OP_POINT_0: rdata_next = op_point_reg[0];
            OFF_OP_POINT_0 + 8'h01: rdata_next = op_point_reg[1];
            OFF_OP_POINT_0 + 8'h02: rdata_next = op_point_reg[2];
            OFF_OP_POINT_0 + 8'h03: rdata_next = op_point_reg[3];
            OFF_DUTY_0: rdata_next = duty_w[0];
            OFF_DUTY_0 + 8'h01: rdata_next = duty_w[1];
            OFF_DUTY_0 + 8'h02: rdata_next = duty_w[2];
            OFF_DUTY_0 + 8'h03: rdata_next = duty_w[3];
            default: rdata_next = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd_i) begin
            rdata_reg <= rdata_next;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign reg_rdata_o = rdata_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_ctrl_readback;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == 8'h0B ##1 reg_rd_i && reg_addr_i == 8'h0B
            |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("start control register readback mismatch");

    property p_alarm_low;
        @(posedge ref_clk_i) disable iff (!arst_n_i)
        !thermal_alarm_input_n_i ##1 !thermal_alarm_input_n_i
            ##1 !thermal_alarm_input_n_i |-> alarm_act;
    endproperty
    a_alarm_low: assert property (p_alarm_low)
        else $error("alarm held low not seen as asserted");

    generate
        for (g = 0; g < NUM_CAP; g++) begin : g_cap_chk
            property p_capture;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                cap_en[g] && alarm_act
                    |=> op_point_o[g] == $past(remote_temp_i[g]);
            endproperty
            a_capture: assert property (p_capture)
                else $error("operating point not captured on alarm");

            property p_ignore;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                !cap_en[g] && !(reg_wr_i &&
                    reg_addr_i == OFF_OP_POINT_0 + 8'(g))
                    |=> $stable(op_point_o[g]);
            endproperty
            a_ignore: assert property (p_ignore)
                else $error("operating point moved while capture off");
        end

        for (g = 0; g < NUM_PWM; g++) begin : g_ramp_chk
            property p_direct;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                duty_update_i[g] && !smooth_en[g]
                    |=> duty_w[g] == $past(auto_duty_i[g]);
            endproperty
            a_direct: assert property (p_direct)
                else $error("unsmoothed duty not applied at once");

            property p_up;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                duty_update_i[g] && smooth_en[g] && !slow[g] &&
                    auto_duty_i[g] > duty_w[g]
                    |=> duty_w[g] > $past(duty_w[g]) &&
                        duty_w[g] <= $past(auto_duty_i[g]);
            endproperty
            a_up: assert property (p_up)
                else $error("duty did not rise toward target");

            property p_down;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                duty_update_i[g] && smooth_en[g] && !slow[g] &&
                    auto_duty_i[g] < duty_w[g]
                    |=> duty_w[g] < $past(duty_w[g]) &&
                        duty_w[g] >= $past(auto_duty_i[g]);
            endproperty
            a_down: assert property (p_down)
                else $error("duty did not fall toward target");

            property p_step_size;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                duty_update_i[g] && smooth_en[g] && !slow[g] &&
                    auto_duty_i[g] > duty_w[g] &&
                    auto_duty_i[g] - duty_w[g] > fpr_step(step_code[g])
                    |=> duty_w[g] - $past(duty_w[g]) ==
                        fpr_step($past(step_code[g]));
            endproperty
            a_step_size: assert property (p_step_size)
                else $error("step size differs from selected code");

            property p_no_update_hold;
                @(posedge ref_clk_i) disable iff (!arst_n_i)
                !duty_update_i[g] |=> $stable(duty_w[g]);
            endproperty
            a_no_update_hold: assert property (p_no_update_hold)
                else $error("duty changed without an update");
        end
    endgenerate

    c_capture: cover property (@(posedge ref_clk_i)
        disable iff (!arst_n_i) cap_en[0] && alarm_act);
    c_ramp_up: cover property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        duty_update_i[0] && smooth_en[0] && auto_duty_i[0] > duty_w[0]);
    c_ramp_down: cover property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        duty_update_i[1] && smooth_en[1] && auto_duty_i[1] < duty_w[1]);
    c_slow: cover property (@(posedge ref_clk_i)
        disable iff (!arst_n_i)
        duty_update_i[2] && smooth_en[2] && slow[2]);
endmodule
`default_nettype wire

// *** tb/fpr_fan_model.sv ***
// Fan load model that measures the PWM high time of each pulse
`timescale 1ns/1ps
`default_nettype none
module fpr_fan_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Drive from the controller
    input wire logic pwm_i,
    // High time of the last finished pulse, in clocks
    output logic [15:0] high_clks_o
);
    logic [15:0] run_reg;
    logic pwm_reg;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_reg <= 16'h0000;
            pwm_reg <= 1'b0;
            high_clks_o <= 16'h0000;
        end else begin
            pwm_reg <= pwm_i;
            run_reg <= pwm_i ? run_reg + 16'h0001 : 16'h0000;
            if (pwm_reg && !pwm_i) begin
                high_clks_o <= run_reg;
            end
        end
    end
endmodule
`default_nettype wire

// *** tb/test_fpr_fan_ramp_limiter.sv ***
// Self-checking bench for the fan ramp limiter
`timescale 1ns/1ps
`default_nettype none
module test_fpr_fan_ramp_limiter;
    import fpr_pkg::*;
    typedef struct {
        logic [7:0] ctrl;
        logic [1:0] ch;
        logic [7:0] step;
    } fpr_row_t;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] rdata;
    logic [NUM_PWM-1:0][7:0] duty_in = '0;
    logic [NUM_PWM-1:0] upd_s = '0;
    logic [NUM_CAP-1:0][7:0] temps = {8'h43, 8'h42, 8'h41, 8'h40};
    logic alarm_n = 1'b1;
    logic [NUM_PWM-1:0] pwm;
    logic [NUM_CAP-1:0][7:0] op_pt;
    logic [15:0] fan_hi;
    logic [7:0] d;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    fpr_row_t rows[8] = '{'{8'h01, 2'd0, 8'h01}, '{8'h22, 2'd1, 8'h02},
        '{8'h09, 2'd2, 8'h03}, '{8'h62, 2'd3, 8'h05},
        '{8'h11, 2'd0, 8'h08}, '{8'hA2, 2'd1, 8'h0C},
        '{8'h19, 2'd2, 8'h18}, '{8'hE2, 2'd3, 8'h30}};

    fpr_fan_ramp_limiter dut_u (.ref_clk_i(clk), .arst_n_i(arst_n),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd_s), .reg_rdata_o(rdata), .auto_duty_i(duty_in),
        .duty_update_i(upd_s), .remote_temp_i(temps),
        .thermal_alarm_input_n_i(alarm_n), .pwm_o(pwm), .op_point_o(op_pt));
    fpr_fan_model fan_u (.ref_clk_i(clk), .arst_n_i(arst_n),
        .pwm_i(pwm[1]), .high_clks_o(fan_hi));

    initial begin
        forever #50 clk = ~clk;
    end
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic upd(input logic [3:0] m, input logic [7:0] t);
        @(posedge clk);
        for (int k = 0; k < NUM_PWM; k++) begin
            if (m[k]) duty_in[k] <= t;
        end
        upd_s <= m;
        @(posedge clk);
        upd_s <= 4'h0;
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            error_cnt++;
            $display("timeout at %0t", $time);
            conclude();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            logic [7:0] ra;
            logic [3:0] m;
            ra = rows[i].ch[1] ? OFF_SMOOTH_B : OFF_SMOOTH_A;
            m = 4'h1 << rows[i].ch;
            rreg(ra, d);
            if (i == 0 || i == 2) chk(d, 8'h00);
            wreg(ra, 8'h00);
            upd(m, 8'hC8);
            rreg(OFF_DUTY_0 + rows[i].ch, d);
            chk(d, 8'hC8);
            upd(m, 8'h00);
            wreg(ra, rows[i].ctrl);
            rreg(ra, d);
            chk(d, rows[i].ctrl);
            upd(m, 8'hC8);
            rreg(OFF_DUTY_0 + rows[i].ch, d);
            chk(d, rows[i].step);
            upd(m, 8'h00);
            rreg(OFF_DUTY_0 + rows[i].ch, d);
            chk(d, 8'h00);
        end
        $display("test step table done");
        wreg(OFF_SMOOTH_A, 8'h1D);
        foreach (rows[i]) begin
            if (i < 4) begin
                upd(4'h1, 8'h64);
                rreg(OFF_DUTY_0, d);
                chk(d, i == 0 ? 8'h30 : i == 1 ? 8'h60 : 8'h64);
            end
        end
        $display("test landing done");
        wreg(OFF_PWM_CFG_0, 8'h08);
        wreg(OFF_SMOOTH_A, 8'h01);
        for (int i = 1; i <= 4; i++) begin
            upd(4'h1, 8'h5A);
            rreg(OFF_DUTY_0, d);
            chk(d, i == 4 ? 8'h63 : 8'h64);
        end
        wreg(OFF_PWM_CFG_0, 8'h00);
        $display("test slow done");
        wreg(OFF_SMOOTH_B, 8'h00);
        upd(4'hF, 8'h1E);
        for (int k = 0; k < NUM_PWM; k++) begin
            rreg(OFF_DUTY_0 + k[7:0], d);
            chk(d, k == 0 ? 8'h62 : 8'h1E);
        end
        repeat (6000) @(posedge clk);
        chk(fan_hi, 16'd300);
        $display("test independence and pwm done");
        // Back-to-back write then read of the start control register
        @(posedge clk);
        addr <= OFF_DYN_START_A;
        wdata <= 8'h04;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1 chk(rdata, 8'h04);
        wreg(OFF_OP_POINT_0 + 8'h01, 8'h55);
        alarm_n <= 1'b0;
        repeat (6) @(posedge clk);
        alarm_n <= 1'b1;
        #1 chk(op_pt[0], 8'h40);
        chk(op_pt[1], 8'h55);
        rreg(OFF_DYN_START_A, d);
        chk(d, 8'h04);
        $display("test alarm capture done");
        wreg(OFF_DUTY_0, 8'hAA);
        rreg(OFF_DUTY_0, d);
        chk(d, 8'h62);
        rreg(8'hFF, d);
        chk(d, 8'h00);
        $display("test register map done");
        conclude();
    end
endmodule
`default_nettype wire
